// >>> rtl/llsr_consts.svh
// Constants of the lane link status register bank
// Included by the counter, the register bank and the bench; definitions only
`ifndef LLSR_CONSTS_SVH
`define LLSR_CONSTS_SVH
`define LLSR_IDX_LINK_PAGE 12'h300
`define LLSR_IDX_LANE0 12'h4b0
`define LLSR_IDX_LANE1 12'h4b1
`define LLSR_IDX_ERR_LIMIT 12'h4c0
`define LLSR_IDX_CNT_CTRL 12'h4c1
`define LLSR_IDX_IRQ_STAT 12'h4c2
`define LLSR_IDX_IRQ_MASK 12'h4c3
`define LLSR_BIT_DISP 7
`define LLSR_BIT_TABLE 6
`define LLSR_BIT_CTRLCH 5
`define LLSR_BIT_DESKEW 4
`define LLSR_BIT_ILAS 3
`define LLSR_BIT_CSUM 2
`define LLSR_BIT_FRAME 1
`define LLSR_BIT_CGS 0
`define LLSR_STATUS_RESET 8'h00
`define LLSR_LIMIT_RESET 8'hff
`define LLSR_CNT_TERMINAL 8'hff
`endif

// >>> rtl/llsr_pkg.sv
// Types shared by the lane link status register bank
package llsr_pkg;
    typedef struct packed {
        logic deskew_ok;
        logic ilas_ok;
        logic csum_ok;
        logic frame_ok;
        logic cgs_ok;
    } llsr_sync_type;
    typedef struct packed {
        logic disp_err;
        logic table_err;
        logic ctrl_err;
    } llsr_err_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACCESS = 3'b010,
        ST_DONE = 3'b100
    } llsr_apb_state_type;
endpackage

// >>> rtl/llsr_err_counter.sv
// One 8-bit lane error counter with hold option and threshold flag
// Assumes error pulses synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
`include "llsr_consts.svh"
module llsr_err_counter
#(
    parameter int WIDTH = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic err_pulse,
    input wire logic clear,
    input wire logic saturate,
    input wire logic [WIDTH-1:0] limit,
    output logic [WIDTH-1:0] count,
    output logic at_limit
);
    initial
    begin
        if (WIDTH != 8)
            $error("llsr_err_counter supports WIDTH 8 only");
    end
    logic [WIDTH-1:0] cnt_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_r <= '0;
        else if (clear)
            cnt_r <= '0;
        else if (err_pulse && !(saturate && cnt_r == `LLSR_CNT_TERMINAL))
            cnt_r <= cnt_r + 8'h01;
    end
    assign count = cnt_r;
    assign at_limit = (cnt_r >= limit);
    a_cnt_hold: assert property (@(posedge pclk) disable iff (!presetn)
        saturate && !clear && cnt_r == `LLSR_CNT_TERMINAL
        |=> cnt_r == `LLSR_CNT_TERMINAL)
        else $error("counter left terminal count while held");
    a_cnt_roll: assert property (@(posedge pclk) disable iff (!presetn)
        !saturate && !clear && err_pulse && cnt_r == `LLSR_CNT_TERMINAL
        |=> cnt_r == 8'h00)
        else $error("counter did not roll over");
endmodule // llsr_err_counter
`default_nettype wire

// >>> rtl/llsr_lane_status.sv
// Lane link status register bank for two lanes and two links, APB slave
// Assumes status inputs and error pulses from receiver logic on pclk
//
// Notes on behaviour
// - Bit 7: disparity count at or above limit
// - Bit 6: table miss count at or above limit
// - Bit 5: control char count at or above limit
// - Bit 4: interlane deskew achieved
// - Bit 3: initial lane sync achieved
// - Bit 2: configuration checksum correct
// - Bit 1: frame sync achieved
// - Bit 0: code group sync achieved
// - Lane 0 layout equals lane 1 layout
// - Link page selects which link is read
// - Lane 1 status at 0x4b1, read-only, reset 0
// - Lane 0 status at 0x4b0, reset 0
// - Counters saturate at 0xff or roll over
`timescale 1ns/10ps
`default_nettype none
`include "llsr_consts.svh"
module llsr_lane_status
import llsr_pkg::*;
#(
    parameter int NUM_LINKS = 2,
    parameter int NUM_LANES = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire llsr_sync_type [NUM_LINKS*NUM_LANES-1:0] sync_in,
    input wire llsr_err_type [NUM_LINKS*NUM_LANES-1:0] err_in,
    output logic irq
);
    initial
    begin
        if (NUM_LINKS != 2 || NUM_LANES != 2)
            $error("llsr_lane_status supports two links of two lanes");
    end
    localparam int NCH = NUM_LINKS * NUM_LANES;

    logic link_page_r;
    logic [7:0] limit_r;
    logic [2:0] cnt_ctrl_r;
    logic [7:0] irq_stat_r;
    logic [7:0] irq_mask_r;
    logic [7:0] status_r [NCH];
    logic [7:0] status_nxt [NCH];
    logic [7:0] prev_r [NCH];
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic irq_r;
    llsr_apb_state_type state_r;

    logic [11:0] idx;
    logic acc;
    logic wr;
    logic mapped;
    logic [31:0] rd_val;
    logic [NCH-1:0] clr_cnt;
    logic [7:0] ev_set;
    logic [7:0] w1c;

    assign idx = paddr[13:2];
    assign acc = psel && penable && state_r == ST_ACCESS;
    // Writes land only at the completing edge, where pready is seen high
    assign wr = psel && penable && pready_r && pwrite;

    // Bit 0 clears link 0 counters, bit 1 link 1, bit 2 enables hold
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_lane
            logic [7:0] c0;
            logic [7:0] c1;
            logic [7:0] c2;
            logic f0;
            logic f1;
            logic f2;
            assign clr_cnt[g] = wr && idx == `LLSR_IDX_CNT_CTRL
                && pwdata[g / NUM_LANES];
            llsr_err_counter #(.WIDTH(8)) u_disp (
                .pclk(pclk), .presetn(presetn), .err_pulse(err_in[g].disp_err),
                .clear(clr_cnt[g]), .saturate(cnt_ctrl_r[2]),
                .limit(limit_r), .count(c0), .at_limit(f0));
            llsr_err_counter #(.WIDTH(8)) u_table (
                .pclk(pclk), .presetn(presetn),
                .err_pulse(err_in[g].table_err),
                .clear(clr_cnt[g]), .saturate(cnt_ctrl_r[2]),
                .limit(limit_r), .count(c1), .at_limit(f1));
            llsr_err_counter #(.WIDTH(8)) u_ctrl (
                .pclk(pclk), .presetn(presetn), .err_pulse(err_in[g].ctrl_err),
                .clear(clr_cnt[g]), .saturate(cnt_ctrl_r[2]),
                .limit(limit_r), .count(c2), .at_limit(f2));
            always_comb
            begin
                status_nxt[g] = `LLSR_STATUS_RESET;
                status_nxt[g][`LLSR_BIT_DISP] = f0;
                status_nxt[g][`LLSR_BIT_TABLE] = f1;
                status_nxt[g][`LLSR_BIT_CTRLCH] = f2;
                status_nxt[g][`LLSR_BIT_DESKEW] = sync_in[g].deskew_ok;
                status_nxt[g][`LLSR_BIT_ILAS] = sync_in[g].ilas_ok;
                status_nxt[g][`LLSR_BIT_CSUM] = sync_in[g].csum_ok;
                status_nxt[g][`LLSR_BIT_FRAME] = sync_in[g].frame_ok;
                status_nxt[g][`LLSR_BIT_CGS] = sync_in[g].cgs_ok;
            end
            // Status follows the receiver and the counter flags; bus writes never land here
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    status_r[g] <= `LLSR_STATUS_RESET;
                    prev_r[g] <= `LLSR_STATUS_RESET;
                end
                else
                begin
                    status_r[g] <= status_nxt[g];
                    prev_r[g] <= status_r[g];
                end
            end
        end
    endgenerate

    // APB handshake: setup, access, one cycle of answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= ST_IDLE;
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (psel && !penable)
                        state_r <= ST_ACCESS;
                ST_ACCESS:
                    if (psel && penable)
                        state_r <= ST_DONE;
                ST_DONE:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link_page_r <= 1'b0;
            limit_r <= `LLSR_LIMIT_RESET;
            cnt_ctrl_r <= 3'h0;
            irq_mask_r <= 8'h00;
        end
        else if (wr)
        begin
            case (idx)
                `LLSR_IDX_LINK_PAGE: link_page_r <= pwdata[0];
                `LLSR_IDX_ERR_LIMIT: limit_r <= pwdata[7:0];
                `LLSR_IDX_CNT_CTRL: cnt_ctrl_r <= {pwdata[2], 2'b00};
                `LLSR_IDX_IRQ_MASK: irq_mask_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Sticky events: loss of any sync bit on any lane, or threshold reached
    always_comb
    begin
        ev_set = 8'h00;
        for (int i = 0; i < NCH; i++)
        begin
            ev_set[i] = ev_set[i] | (|(prev_r[i][4:0] & ~status_r[i][4:0]));
            ev_set[i+4] = ev_set[i+4]
                | (|(status_r[i][7:5] & ~prev_r[i][7:5]));
        end
    end
    assign w1c = (wr && idx == `LLSR_IDX_IRQ_STAT) ? pwdata[7:0] : 8'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_r <= 8'h00;
            irq_r <= 1'b0;
        end
        else
        begin
            irq_stat_r <= (irq_stat_r & ~w1c) | ev_set;
            irq_r <= |(((irq_stat_r & ~w1c) | ev_set) & irq_mask_r);
        end
    end

    always_comb
    begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (idx)
            `LLSR_IDX_LINK_PAGE: rd_val = {31'h0, link_page_r};
            `LLSR_IDX_LANE0: rd_val = {24'h0, status_r[{link_page_r, 1'b0}]};
            `LLSR_IDX_LANE1: rd_val = {24'h0, status_r[{link_page_r, 1'b1}]};
            `LLSR_IDX_ERR_LIMIT: rd_val = {24'h0, limit_r};
            `LLSR_IDX_CNT_CTRL: rd_val = {29'h0, cnt_ctrl_r};
            `LLSR_IDX_IRQ_STAT: rd_val = {24'h0, irq_stat_r};
            `LLSR_IDX_IRQ_MASK: rd_val = {24'h0, irq_mask_r};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= acc;
            pslverr_r <= acc && !mapped;
            if (acc && !pwrite)
                prdata_r <= rd_val;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;

    a_lane1_disp: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 status_r[1][7] == $past(g_lane[1].f0))
        else $error("lane 1 disparity flag wrong");
    a_lane0_table: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 status_r[0][6] == $past(g_lane[0].c1 >= limit_r))
        else $error("lane 0 table flag wrong");
    a_lane1_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 status_r[1][5] == $past(g_lane[1].c2 >= limit_r))
        else $error("lane 1 control char flag wrong");
    a_deskew_bit: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 status_r[2][4] == $past(sync_in[2].deskew_ok))
        else $error("deskew bit wrong");
    a_ilas_bit: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 status_r[3][3] == $past(sync_in[3].ilas_ok))
        else $error("initial lane sync bit wrong");
    a_csum_bit: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 status_r[0][2] == $past(sync_in[0].csum_ok))
        else $error("checksum bit wrong");
    a_frame_cgs: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 status_r[1][1:0] == $past({sync_in[1].frame_ok,
        sync_in[1].cgs_ok}))
        else $error("frame or code group bit wrong");
    a_page_read: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !pwrite && idx == `LLSR_IDX_LANE1
        |=> pready && prdata[7:0] == $past(status_r[{link_page_r, 1'b1}])
        && prdata[31:8] == 24'h0)
        else $error("paged lane 1 read wrong");
    a_ro_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && idx == `LLSR_IDX_LANE0 |-> pready && !pslverr)
        else $error("status write not absorbed");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq == |($past(irq_stat_r & ~w1c | ev_set) & $past(irq_mask_r)))
        else $error("interrupt level wrong");
    c_read_lane0: cover property (@(posedge pclk)
        acc && !pwrite && idx == `LLSR_IDX_LANE0);
    c_page1: cover property (@(posedge pclk) link_page_r && acc && !pwrite);
    c_irq: cover property (@(posedge pclk) irq);
    c_bad_addr: cover property (@(posedge pclk) pslverr);
endmodule // llsr_lane_status
`default_nettype wire

// >>> tb/llsr_rx_model.sv
// Receiver-side stand-in: lane sync levels and error pulses
// Assumes the bench calls its tasks in the pclk domain
`timescale 1ns/10ps
`default_nettype none
module llsr_rx_model
import llsr_pkg::*;
(
    input wire logic pclk,
    output var llsr_sync_type [3:0] sync_in,
    output var llsr_err_type [3:0] err_in
);
    initial
    begin
        sync_in = '0;
        err_in = '0;
    end
    task automatic set_sync(input int ch, input logic [4:0] v);
        @(posedge pclk);
        sync_in[ch] <= v;
    endtask
    // Pulse drops between errors so each one counts once
    task automatic errs(input int ch, input int kind, input int n);
        repeat (n)
        begin
            @(posedge pclk);
            err_in[ch][kind] <= 1'b1;
            @(posedge pclk);
            err_in[ch][kind] <= 1'b0;
        end
    endtask
endmodule // llsr_rx_model
`default_nettype wire

// >>> tb/llsr_lane_status_test.sv
// Bench for the lane link status bank: APB tasks and sequenced checks
// Assumes llsr_rx_model drives the receiver-side inputs
`timescale 1ns/10ps
`default_nettype none
`include "llsr_consts.svh"
module llsr_lane_status_test
import llsr_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    llsr_sync_type [3:0] sync_in;
    llsr_err_type [3:0] err_in;
    int errors, samples_checked;
    llsr_lane_status llsr_lane_status_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sync_in(sync_in), .err_in(err_in), .irq(irq));
    llsr_rx_model llsr_rx_model_i (.pclk(pclk), .sync_in(sync_in),
        .err_in(err_in));
    task automatic chk(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] idx,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            errors++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Settle time lets registered status catch up with the inputs
    task automatic rdchk(input logic [11:0] idx, input logic [31:0] e,
        input string nm);
        repeat (3) @(posedge pclk);
        apb(1'b0, idx, 32'h0);
        chk(nm, rd, e);
    endtask
    initial
    begin
        pclk = 1'b0;
        forever
            #20 pclk = ~pclk;
    end
    initial
    begin
        errors = 0;
        samples_checked = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int p = 0; p < 2; p++)
        begin
            apb(1'b1, `LLSR_IDX_LINK_PAGE, 32'(p));
            rdchk(`LLSR_IDX_LANE0, 32'h0, "lane0 reset");
            rdchk(`LLSR_IDX_LANE1, 32'h0, "lane1 reset");
        end
        rdchk(`LLSR_IDX_ERR_LIMIT, 32'hff, "limit reset");
        for (int b = 0; b < 5; b++)
        begin
            for (int c = 0; c < 4; c++)
                llsr_rx_model_i.set_sync(c, 5'h1f ^ (5'h1 << ((b + c) % 5)));
            for (int c = 0; c < 4; c++)
            begin
                apb(1'b1, `LLSR_IDX_LINK_PAGE, 32'(c / 2));
                rdchk(12'(`LLSR_IDX_LANE0 + c % 2),
                    32'h1f ^ (32'h1 << ((b + c) % 5)), "sync");
            end
        end
        apb(1'b1, `LLSR_IDX_LANE1, 32'hff);
        chk("status write err", {31'h0, err}, 32'h0);
        rdchk(`LLSR_IDX_LANE1, 32'h1b, "status write");
        apb(1'b0, 12'h4ff, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        for (int c = 0; c < 4; c++)
            llsr_rx_model_i.set_sync(c, 5'h1f);
        apb(1'b1, `LLSR_IDX_ERR_LIMIT, 32'h3);
        apb(1'b1, `LLSR_IDX_LINK_PAGE, 32'h0);
        llsr_rx_model_i.errs(0, 2, 2);
        rdchk(`LLSR_IDX_LANE0, 32'h1f, "disp below");
        llsr_rx_model_i.errs(0, 2, 1);
        rdchk(`LLSR_IDX_LANE0, 32'h9f, "disp at");
        llsr_rx_model_i.errs(1, 1, 3);
        rdchk(`LLSR_IDX_LANE1, 32'h5f, "table");
        llsr_rx_model_i.errs(3, 0, 3);
        apb(1'b1, `LLSR_IDX_LINK_PAGE, 32'h1);
        rdchk(`LLSR_IDX_LANE1, 32'h3f, "ctrl char");
        apb(1'b1, `LLSR_IDX_IRQ_STAT, 32'hff);
        rdchk(`LLSR_IDX_IRQ_STAT, 32'h0, "irq clear");
        apb(1'b1, `LLSR_IDX_IRQ_MASK, 32'h1);
        llsr_rx_model_i.set_sync(0, 5'h0f);
        rdchk(`LLSR_IDX_IRQ_STAT, 32'h1, "irq status");
        chk("irq on", {31'h0, irq}, 32'h1);
        apb(1'b1, `LLSR_IDX_IRQ_STAT, 32'h1);
        repeat (3) @(posedge pclk);
        chk("irq off", {31'h0, irq}, 32'h0);
        apb(1'b1, `LLSR_IDX_ERR_LIMIT, 32'hff);
        apb(1'b1, `LLSR_IDX_CNT_CTRL, 32'h6);
        llsr_rx_model_i.errs(2, 2, 256);
        rdchk(`LLSR_IDX_LANE0, 32'h9f, "hold");
        apb(1'b1, `LLSR_IDX_CNT_CTRL, 32'h2);
        llsr_rx_model_i.errs(2, 2, 256);
        rdchk(`LLSR_IDX_LANE0, 32'h1f, "roll over");
        report_and_stop();
    end
endmodule // llsr_lane_status_test
`default_nettype wire
